// File: cache_map_pkg.sv
// constants and types for the memory-mapped cache array window
// assumes a single 250 MHz core clock domain and 32-bit data words
package cache_map_pkg;

  // ****************
  // array select codes in address bits 31..24
  // ****************
  localparam logic [7:0] IC_DATA_CODE = 8'hF1;
  localparam logic [7:0] OC_ADDR_CODE = 8'hF4;
  localparam logic [7:0] OC_DATA_CODE = 8'hF5;
  localparam int CODE_HI = 31;
  localparam int CODE_LO = 24;

  // ****************
  // address field positions
  // ****************
  localparam int IC_WAY_BIT = 13;
  localparam int IC_ENT_HI = 12;
  localparam int OC_WAY_BIT = 14;
  localparam int OC_ENT_HI = 13;
  localparam int OC_RAM_WAY_BIT = 13;
  localparam int OC_RAM_ENT_HI = 12;
  localparam int ENT_LO = 5;
  localparam int WORD_HI = 4;
  localparam int WORD_LO = 2;
  localparam int ASSOC_BIT = 3;

  // ****************
  // address array data word layout
  // ****************
  localparam int TAG_W = 19;
  localparam int VPN_W = 22;
  localparam int TAG_FIELD_HI = 31;
  localparam int TAG_STORED_HI = 28;
  localparam int TAG_LO = 10;
  localparam int DIRTY_BIT = 1;
  localparam int VALID_BIT = 0;

  // ****************
  // array geometry
  // ****************
  localparam int WAYS = 2;
  localparam int OC_ENTRIES = 512;
  localparam int ENT_W = 9;
  localparam int WORD_W = 3;
  localparam int LINE_WORDS = 8;
  localparam logic [WORD_W-1:0] LAST_WORD = 3'h7;

  // ****************
  // block control and status words
  // ****************
  localparam logic [31:0] CTRL_ADDR = 32'hFF80_0000;
  localparam logic [31:0] STATUS_ADDR = 32'hFF80_0004;
  localparam int CTRL_MMU_BIT = 0;
  localparam int CTRL_RAM_BIT = 1;
  localparam int CTRL_IDX_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int STAT_HIT_BIT = 0;
  localparam int STAT_MISS_BIT = 1;
  localparam int STAT_MULTI_BIT = 2;
  localparam logic [2:0] STAT_RESET = 3'h0;

  typedef enum {
    TGT_NONE,
    TGT_IC_DATA,
    TGT_OC_ADDR,
    TGT_OC_DATA,
    TGT_CTRL,
    TGT_STATUS
  } target_t;

endpackage

// File: cache_addr_decode.sv
// address decoder for the cache array window
// assumes a longword address from the load/store side, purely combinational
`timescale 1ns/1ps
module cache_addr_decode
  import cache_map_pkg::*;
(
  input wire logic [31:0] addr_i, // access address
  input wire logic ram_mode_i, // operand cache ram mode
  output target_t target_o, // decoded array
  output logic way_o, // way select
  output logic [ENT_W-1:0] entry_o, // entry select
  output logic [WORD_W-1:0] word_o, // longword in line
  output logic assoc_o // associate flag
);

  // ****************
  // field extraction
  // ****************
  // R24 - shadows decode alike
  // unused address bits fall through, so every shadow decodes alike
  always_comb begin
    target_o = TGT_NONE;
    way_o = addr_i[OC_WAY_BIT];
    entry_o = addr_i[OC_ENT_HI:ENT_LO];
    word_o = addr_i[WORD_HI:WORD_LO];
    // R07 - associate flag
    assoc_o = addr_i[ASSOC_BIT];
    if (addr_i == CTRL_ADDR) begin
      target_o = TGT_CTRL;
    end else if (addr_i == STATUS_ADDR) begin
      target_o = TGT_STATUS;
    end else if (addr_i[CODE_HI:CODE_LO] == IC_DATA_CODE) begin
      // R01 - way and entry
      target_o = TGT_IC_DATA;
      way_o = addr_i[IC_WAY_BIT];
      entry_o = {1'b0, addr_i[IC_ENT_HI:ENT_LO]};
    end else if (addr_i[CODE_HI:CODE_LO] == OC_ADDR_CODE ||
                 addr_i[CODE_HI:CODE_LO] == OC_DATA_CODE) begin
      // R03 - address array code
      // R20 - data array code
      target_o = (addr_i[CODE_HI:CODE_LO] == OC_ADDR_CODE) ?
                 TGT_OC_ADDR : TGT_OC_DATA;
      // R05 - fixed index bits
      if (ram_mode_i) begin
        // R06 - ram mode way
        // R23 - 16 KB shadows
        way_o = addr_i[OC_RAM_WAY_BIT];
        entry_o = {1'b0, addr_i[OC_RAM_ENT_HI:ENT_LO]};
      end else begin
        // R04 - normal way entry
        // R22 - 32 KB shadows
        way_o = addr_i[OC_WAY_BIT];
        entry_o = addr_i[OC_ENT_HI:ENT_LO];
      end
    end
  end

endmodule

// File: cache_array_mapped_access.sv
// memory-mapped access to the cache tag and data arrays over apb
// assumes privileged longword accesses, a translation port and a
// write-back port to memory, all in the core clock domain
//
// Behaviour
// R01 - instruction data array: code F1, way bit 13, entry bits 12..5
// R02 - instruction data read returns, write replaces, the selected longword
// R03 - address array decoded by code F4 over its whole 16 MB window
// R04 - normal mode: way from bit 14, entry from bits 13..5
// R05 - entry selection ignores the index mode bit
// R06 - ram mode: arrays only through window, way from bit 13
// R07 - address bit 3 picks associative or direct address array write
// R08 - accessor uses longwords with address bits 1..0 at zero
// R09 - tag in bits 31..10, dirty in bit 1, valid in bit 0
// R10 - stored tag 19 bits; top three bits only feed translation
// R11 - address array read returns tag and flags, never compares
// R12 - direct write stores tag and flags; accessor keeps associate clear
// R13 - valid dirty target is written back before a direct write
// R14 - associative write compares tags of every way at the entry
// R15 - with translation on, translate before the compare
// R16 - hit on a valid way writes only dirty and valid flags
// R17 - hit dirty line losing valid or dirty is written back
// R18 - translation miss or tag mismatch drops the write silently
// R19 - translation multiple hit raises the multiple hit exception
// R20 - data array code F5, address bits 4..2 pick the longword
// R21 - data array read returns longword; write leaves dirty unchanged
// R22 - normal mode: 512 entries per way, pair repeats every 32 KB
// R23 - ram mode: 256 entries per way, pair repeats every 16 KB
// R24 - unused address bits ignored, giving shadow copies
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module cache_array_mapped_access
  import cache_map_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [31:0] paddr_i, // apb address
  input wire logic [31:0] pwdata_i, // apb write data
  input wire logic [3:0] pstrb_i, // apb byte strobes
  input wire logic [2:0] pprot_i, // apb protection
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  output logic tlb_req_o, // translation request
  output logic [VPN_W-1:0] tlb_vpn_o, // virtual page to translate
  input wire logic tlb_done_i, // translation answer
  input wire logic tlb_hit_i, // translation hit
  input wire logic tlb_multi_i, // translation multiple hit
  input wire logic [TAG_W-1:0] tlb_ppn_i, // physical page
  output logic wb_valid_o, // write-back word valid
  output logic [31:0] wb_addr_o, // write-back line address
  output logic [31:0] wb_data_o, // write-back word
  output logic wb_last_o, // last word of line
  input wire logic wb_ready_i, // memory took the word
  output logic multi_hit_exc_o // multiple hit exception pulse
);

  typedef enum {ST_IDLE, ST_TLB, ST_CMP, ST_WB, ST_RESP} state_t;

  // ****************
  // storage
  // ****************
  logic [31:0] ic_data [WAYS*256*LINE_WORDS];
  logic [31:0] oc_data [WAYS*OC_ENTRIES*LINE_WORDS];
  logic [TAG_W-1:0] oc_tag [WAYS][OC_ENTRIES];
  logic [OC_ENTRIES-1:0] oc_valid [WAYS];
  logic [OC_ENTRIES-1:0] oc_dirty [WAYS];

  state_t state;
  logic [2:0] ctrl;
  logic [2:0] status;
  target_t op_target;
  logic op_way;
  logic [ENT_W-1:0] op_entry;
  logic op_assoc;
  logic [31:0] op_wdata;
  logic [TAG_W-1:0] cmp_tag;
  logic op_err;
  logic [WORD_W-1:0] wb_word;
  logic [31:0] rdata;

  target_t dec_target;
  logic dec_way;
  logic [ENT_W-1:0] dec_entry;
  logic [WORD_W-1:0] dec_word;
  logic dec_assoc;

  logic start;
  logic bad;
  logic hit0;
  logic hit1;
  logic hit_any;
  logic hit_way;
  logic hit_wb;
  logic tgt_dirty_valid;
  logic tagw_en;
  logic tagw_full;
  logic tagw_way;
  logic [ENT_W-1:0] tagw_entry;
  logic [31:0] tagw_data;
  logic wb_enter;
  logic wb_enter_way;
  logic [ENT_W-1:0] wb_enter_entry;
  logic wb_step;
  logic wb_done;
  logic [WORD_W-1:0] next_wb_word;

  cache_addr_decode u_decode (
    .addr_i(paddr_i),
    .ram_mode_i(ctrl[CTRL_RAM_BIT]),
    .target_o(dec_target),
    .way_o(dec_way),
    .entry_o(dec_entry),
    .word_o(dec_word),
    .assoc_o(dec_assoc)
  );

  // ****************
  // request qualification
  // ****************
  // a new transfer is only looked at while nothing is in flight
  assign start = (state == ST_IDLE) && psel_i && penable_i;

  // R08 - refuse odd accesses
  // misaligned, partial, unprivileged or unmapped accesses answer slverr
  assign bad = (dec_target == TGT_NONE) || !pprot_i[0] ||
               (paddr_i[1:0] != 2'h0) ||
               (pwrite_i && pstrb_i != 4'hF);

  // R13 - detect dirty target
  assign tgt_dirty_valid = oc_valid[dec_way][dec_entry] &&
                           oc_dirty[dec_way][dec_entry];

  // R14 - compare every way
  // the way bit of the address plays no part here
  assign hit0 = oc_valid[0][op_entry] && (oc_tag[0][op_entry] == cmp_tag);
  assign hit1 = oc_valid[1][op_entry] && (oc_tag[1][op_entry] == cmp_tag);
  assign hit_any = hit0 || hit1;
  assign hit_way = !hit0;

  // R17 - write-back on invalidate
  assign hit_wb = oc_dirty[hit_way][op_entry] &&
                  (!op_wdata[VALID_BIT] || !op_wdata[DIRTY_BIT]);

  // ****************
  // address array write selection
  // ****************
  always_comb begin
    tagw_en = 1'b0;
    tagw_full = 1'b1;
    tagw_way = dec_way;
    tagw_entry = dec_entry;
    tagw_data = pwdata_i;
    if (start && !bad && pwrite_i && dec_target == TGT_OC_ADDR &&
        !dec_assoc && !tgt_dirty_valid) begin
      // R12 - direct write
      tagw_en = 1'b1;
    end else if (state == ST_CMP && hit_any && !hit_wb) begin
      // R16 - flags only
      tagw_en = 1'b1;
      tagw_full = 1'b0;
      tagw_way = hit_way;
      tagw_entry = op_entry;
      tagw_data = op_wdata;
    end else if (wb_done) begin
      // R13 - store after write-back
      tagw_en = 1'b1;
      tagw_full = !op_assoc;
      tagw_way = op_way;
      tagw_entry = op_entry;
      tagw_data = op_wdata;
    end
  end

  // ****************
  // write-back sequencing
  // ****************
  // entry into write-back, from a direct write or an associative hit
  always_comb begin
    wb_enter = 1'b0;
    wb_enter_way = dec_way;
    wb_enter_entry = dec_entry;
    if (start && !bad && pwrite_i && dec_target == TGT_OC_ADDR &&
        !dec_assoc && tgt_dirty_valid) begin
      wb_enter = 1'b1;
    end else if (state == ST_CMP && hit_any && hit_wb) begin
      wb_enter = 1'b1;
      wb_enter_way = hit_way;
      wb_enter_entry = op_entry;
    end
  end

  assign wb_step = (state == ST_WB) && wb_ready_i;
  assign wb_done = wb_step && (wb_word == LAST_WORD);
  assign next_wb_word = wb_enter ? '0 : wb_word + 3'h1;

  // word counter and registered line word
  // the word is refetched after each acceptance so wb_data_o is a flop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_word <= '0;
      wb_data_o <= 32'h0000_0000;
      wb_addr_o <= 32'h0000_0000;
    end else if (wb_enter) begin
      wb_word <= '0;
      wb_data_o <= oc_data[{wb_enter_way, wb_enter_entry, 3'h0}];
      wb_addr_o <= {3'h0, oc_tag[wb_enter_way][wb_enter_entry],
                    wb_enter_entry[4:0], 5'h00};
    end else if (wb_step && !wb_done) begin
      wb_word <= next_wb_word;
      wb_data_o <= oc_data[{op_way, op_entry, next_wb_word}];
    end
  end

  assign wb_valid_o = (state == ST_WB);
  assign wb_last_o = (state == ST_WB) && (wb_word == LAST_WORD);

  // ****************
  // main sequencer
  // ****************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            if (bad || !pwrite_i || dec_target != TGT_OC_ADDR) begin
              state <= ST_RESP;
            end else if (dec_assoc) begin
              // R15 - translate first
              state <= ctrl[CTRL_MMU_BIT] ? ST_TLB : ST_CMP;
            end else begin
              state <= tgt_dirty_valid ? ST_WB : ST_RESP;
            end
          end
        end
        ST_TLB: begin
          if (tlb_done_i) begin
            state <= (tlb_hit_i && !tlb_multi_i) ? ST_CMP : ST_RESP;
          end
        end
        ST_CMP: begin
          // R18 - mismatch drops
          state <= (hit_any && hit_wb) ? ST_WB : ST_RESP;
        end
        ST_WB: begin
          if (wb_done) begin
            state <= ST_RESP;
          end
        end
        ST_RESP: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // operation context held for the multi-cycle paths
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_target <= TGT_NONE;
      op_way <= 1'b0;
      op_entry <= '0;
      op_assoc <= 1'b0;
      op_wdata <= 32'h0000_0000;
      cmp_tag <= '0;
    end else if (start) begin
      op_target <= dec_target;
      op_way <= dec_way;
      op_entry <= dec_entry;
      op_assoc <= dec_assoc;
      op_wdata <= pwdata_i;
      // R10 - top bits dropped
      cmp_tag <= pwdata_i[TAG_STORED_HI:TAG_LO];
    end else if (state == ST_TLB && tlb_done_i) begin
      cmp_tag <= tlb_ppn_i;
    end else if (state == ST_CMP) begin
      op_way <= hit_way;
    end
  end

  // R15 - translation request
  // the full virtual page from bits 31..10 goes to the translator
  assign tlb_req_o = (state == ST_TLB);
  assign tlb_vpn_o = op_wdata[TAG_FIELD_HI:TAG_LO];

  // R19 - multiple hit exception
  // a one-cycle pulse plus an error answer diverts the pipeline
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      multi_hit_exc_o <= 1'b0;
      op_err <= 1'b0;
    end else begin
      multi_hit_exc_o <= (state == ST_TLB) && tlb_done_i && tlb_multi_i;
      if (start) begin
        op_err <= bad;
      end else if (state == ST_TLB && tlb_done_i && tlb_multi_i) begin
        op_err <= 1'b1;
      end
    end
  end

  // ****************
  // control and status words
  // ****************
  // index mode bit is kept for software but never steers the decode
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= CTRL_RESET;
    end else if (start && !bad && pwrite_i && dec_target == TGT_CTRL) begin
      ctrl <= pwdata_i[2:0];
    end
  end

  // outcome of the most recent associative write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status <= STAT_RESET;
    end else if (start && !bad && pwrite_i && dec_target == TGT_OC_ADDR &&
                 dec_assoc) begin
      status <= STAT_RESET;
    end else if (state == ST_TLB && tlb_done_i) begin
      status[STAT_MISS_BIT] <= !tlb_hit_i && !tlb_multi_i;
      status[STAT_MULTI_BIT] <= tlb_multi_i;
    end else if (state == ST_CMP) begin
      status[STAT_HIT_BIT] <= hit_any;
    end
  end

  // ****************
  // tag and flag arrays
  // ****************
  // tags carry no reset; only the flags need a known value
  always_ff @(posedge clk_i) begin
    if (tagw_en && tagw_full) begin
      // R10 - 19-bit tag
      oc_tag[tagw_way][tagw_entry] <= tagw_data[TAG_STORED_HI:TAG_LO];
    end
  end

  // one flag pair per way, reset to invalid and clean
  for (genvar w = 0; w < WAYS; w++) begin : g_flags
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        oc_valid[w] <= '0;
        oc_dirty[w] <= '0;
      end else if (tagw_en && tagw_way == w) begin
        // R09 - flag positions
        oc_valid[w][tagw_entry] <= tagw_data[VALID_BIT];
        oc_dirty[w][tagw_entry] <= tagw_data[DIRTY_BIT];
      end
    end
  end

  // ****************
  // data arrays
  // ****************
  // R02 - instruction data write
  // R21 - data write, dirty untouched
  always_ff @(posedge clk_i) begin
    if (start && !bad && pwrite_i && dec_target == TGT_IC_DATA) begin
      ic_data[{dec_way, dec_entry[7:0], dec_word}] <= pwdata_i;
    end
    if (start && !bad && pwrite_i && dec_target == TGT_OC_DATA) begin
      oc_data[{dec_way, dec_entry, dec_word}] <= pwdata_i;
    end
  end

  // ****************
  // read path
  // ****************
  // R11 - read never compares
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (dec_target)
      TGT_IC_DATA: rdata = ic_data[{dec_way, dec_entry[7:0], dec_word}];
      TGT_OC_ADDR: rdata = {3'h0, oc_tag[dec_way][dec_entry], 8'h00,
                            oc_dirty[dec_way][dec_entry],
                            oc_valid[dec_way][dec_entry]};
      TGT_OC_DATA: rdata = oc_data[{dec_way, dec_entry, dec_word}];
      TGT_CTRL: rdata = {29'h0, ctrl};
      TGT_STATUS: rdata = {29'h0, status};
      TGT_NONE: rdata = 32'h0000_0000;
    endcase
  end

  // read data captured at the start edge, zero on refused reads
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (start) begin
      prdata_o <= (!pwrite_i && !bad) ? rdata : 32'h0000_0000;
    end
  end

  // ready only in the answer cycle, so each transfer waits at least one cycle after the take
  assign pready_o = (state == ST_RESP);
  assign pslverr_o = (state == ST_RESP) && op_err;

endmodule

// File: cache_map_props.sv
// port assertions for the cache window block
// assumes one clock domain and the async low reset
`timescale 1ns/1ps
module cache_map_props
  import cache_map_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic psel_i, // select
  input wire logic penable_i, // enable
  input wire logic pwrite_i, // write
  input wire logic [31:0] paddr_i, // address
  input wire logic [2:0] pprot_i, // protection
  input wire logic pready_o, // ready
  input wire logic pslverr_o, // error
  input wire logic tlb_req_o, // lookup
  input wire logic tlb_done_i, // answer
  input wire logic tlb_multi_i, // multi hit
  input wire logic wb_valid_o, // wb valid
  input wire logic [31:0] wb_addr_o, // wb address
  input wire logic [31:0] wb_data_o, // wb word
  input wire logic wb_last_o, // wb last
  input wire logic wb_ready_i, // wb taken
  input wire logic multi_hit_exc_o // exception
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ****************
  // request shapes
  // ****************
  sequence take_s;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence refused_s;
    pready_o && pslverr_o;
  endsequence
  // answers are single cycle pulses
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  // only the three array codes and the control and status words decode; f0 is not one of them
  unmapped_err_a: assert property (
    take_s ##0 (paddr_i[31:24] == 8'hF0) |=> refused_s)
    else $error("f0 not refused");
  // plain data reads answer one cycle after the take
  data_read_a: assert property (
    take_s ##0 (!pwrite_i && paddr_i[31:24] == 8'hF5
    && paddr_i[1:0] == 2'h0 && pprot_i[0]) |=> pready_o && !pslverr_o)
    else $error("data read late or refused");
  tlb_hold_a: assert property (
    tlb_req_o && !tlb_done_i |=> tlb_req_o)
    else $error("lookup dropped early");
  tlb_drop_a: assert property (tlb_req_o && tlb_done_i |=> !tlb_req_o)
    else $error("lookup held after answer");
  multi_exc_a: assert property (
    tlb_req_o && tlb_done_i && tlb_multi_i |=> multi_hit_exc_o ##0 refused_s)
    else $error("multi hit not raised");
  exc_cause_a: assert property (
    multi_hit_exc_o |-> $past(tlb_done_i && tlb_req_o && tlb_multi_i))
    else $error("exception without cause");
  // the line address may not wander mid line
  wb_addr_hold_a: assert property (
    wb_valid_o && $past(wb_valid_o) |-> $stable(wb_addr_o))
    else $error("wb address moved");
  wb_data_hold_a: assert property (
    wb_valid_o && !wb_ready_i |=> wb_valid_o && $stable(wb_data_o))
    else $error("wb word dropped");
  wb_before_a: assert property (wb_valid_o |-> !pready_o)
    else $error("answer before write-back");
  wb_end_a: assert property (
    wb_valid_o && wb_last_o && wb_ready_i |-> ##[1:2] pready_o)
    else $error("no answer after write-back");
endmodule

bind cache_array_mapped_access cache_map_props chk (.*);

// File: far_model.sv
// far side model: translation buffer and line memory
// assumes the block's clock and reset
`timescale 1ns/1ps
module far_model
  import cache_map_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic [1:0] mode_i, // 0 miss 1 hit 2 multi
  input wire logic tlb_req_i, // lookup
  input wire logic [VPN_W-1:0] tlb_vpn_i, // page
  output logic tlb_done_o, // answer
  output logic tlb_hit_o, // hit
  output logic tlb_multi_o, // multi hit
  output logic [TAG_W-1:0] tlb_ppn_o, // frame
  input wire logic wb_valid_i, // word valid
  input wire logic [31:0] wb_addr_i, // line address
  input wire logic [31:0] wb_data_i, // word
  output logic wb_ready_o // accepted
);
  logic [1:0] wait_cnt;
  logic slow;
  logic [3:0] wb_n;
  logic [31:0] wb_a;
  logic [31:0] wb_w [8];
  // lookup answers on the third cycle of a request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) wait_cnt <= 2'h0;
    else if (tlb_done_o) wait_cnt <= 2'h0;
    else if (tlb_req_i) wait_cnt <= wait_cnt + 2'h1;
  end
  assign tlb_done_o = tlb_req_i && wait_cnt == 2'h2;
  assign tlb_hit_o = tlb_done_o && mode_i == 2'h1;
  assign tlb_multi_o = tlb_done_o && mode_i == 2'h2;
  // frame scrambled outside the answer so stale use shows
  assign tlb_ppn_o = tlb_done_o ? tlb_vpn_i[TAG_W-1:0] + 19'h1
    : ~tlb_vpn_i[TAG_W-1:0];
  // ready every other cycle, so each word stalls one cycle and the block must hold
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) slow <= 1'h0;
    else slow <= wb_valid_i && !slow;
  end
  assign wb_ready_o = wb_valid_i && slow;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) wb_n <= 4'h0;
    else if (wb_ready_o) wb_n <= wb_n + 4'h1;
  end
  // keep words and line address
  always_ff @(posedge clk_i) begin
    if (wb_ready_o) begin
      wb_w[wb_n[2:0]] <= wb_data_i;
      wb_a <= wb_addr_i;
    end
  end
endmodule

// File: testbench.sv
// self-checking bench for the cache array window
// assumes the far side model and the port checker
`timescale 1ns/1ps
module testbench
  import cache_map_pkg::*;
;
  logic clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [31:0] paddr_i, pwdata_i, prdata_o, wb_addr_o, wb_data_o, r;
  logic [3:0] pstrb_i, n0;
  logic [2:0] pprot_i;
  logic [1:0] tlb_mode;
  logic tlb_req_o, tlb_done_i, tlb_hit_i, tlb_multi_i, e;
  logic wb_valid_o, wb_last_o, wb_ready_i, multi_hit_exc_o;
  logic [VPN_W-1:0] tlb_vpn_o;
  logic [TAG_W-1:0] tlb_ppn_i;
  int fail_count, cmp_count;
  localparam logic [18:0] T = 19'h2A5C3;
  localparam logic [18:0] T2 = 19'h01234;
  localparam logic [31:0] TA = 32'hF400_0040;
  localparam logic [31:0] AS = 32'hF400_4048;
  localparam logic [31:0] LA = {3'h0, T, 5'h02, 5'h00};
  cache_array_mapped_access dut (.clk_i, .arst_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pprot_i, .prdata_o, .pready_o,
    .pslverr_o, .tlb_req_o, .tlb_vpn_o, .tlb_done_i, .tlb_hit_i, .tlb_multi_i,
    .tlb_ppn_i, .wb_valid_o, .wb_addr_o, .wb_data_o, .wb_last_o, .wb_ready_i,
    .multi_hit_exc_o);
  far_model tm (.clk_i, .arst_n_i, .mode_i(tlb_mode), .tlb_req_i(tlb_req_o),
    .tlb_vpn_i(tlb_vpn_o), .tlb_done_o(tlb_done_i), .tlb_hit_o(tlb_hit_i),
    .tlb_multi_o(tlb_multi_i), .tlb_ppn_o(tlb_ppn_i), .wb_valid_i(wb_valid_o),
    .wb_addr_i(wb_addr_o), .wb_data_i(wb_data_o), .wb_ready_o(wb_ready_i));
  // ****************
  // shared tasks
  // ****************
  function automatic logic [31:0] tw(input logic [18:0] t, input logic u, v);
    return {3'h0, t, 8'h00, u, v};
  endfunction
  task automatic results();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch %0t got %h exp %h", $time, g, x);
    end
  endtask
  // request held until the edge that samples ready
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do @(posedge clk_i); while (pready_o !== 1'h1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a, x);
    apb(1'h0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic wbchk(input logic [31:0] a);
    chk({28'h0, tm.wb_n - n0}, 32'h8);
    chk(tm.wb_a, a);
    for (int i = 0; i < 8; i++) begin
      chk(tm.wb_w[i], 32'hA000_0000 + 32'(i));
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_icache();
    rd(CTRL_ADDR, 32'h0);
    rd(STATUS_ADDR, 32'h0);
    apb(1'h0, 32'hF000_0000, 32'h0);
    chk({31'h0, e}, 32'h1); // only f4 is tags
    apb(1'h1, 32'hF100_2024, 32'h1111_2222);
    apb(1'h1, 32'hF100_0024, 32'h3333_4444);
    rd(32'hF1FF_6024, 32'h1111_2222); // shadow
    rd(32'hF100_0024, 32'h3333_4444); // way bit
  endtask
  task automatic t_ocache();
    apb(1'h1, CTRL_ADDR, 32'h4);
    apb(1'h1, 32'hF500_0060, 32'h5555_0000);
    apb(1'h1, 32'hF500_4060, 32'h5555_0001);
    rd(32'hF500_C060, 32'h5555_0001); // shadow
    rd(32'hF500_8060, 32'h5555_0000); // way 0 low
    apb(1'h1, CTRL_ADDR, 32'h2);
    apb(1'h1, 32'hF500_2060, 32'h5555_0002);
    rd(32'hF500_6060, 32'h5555_0002); // shadow
    rd(32'hF500_0060, 32'h5555_0000); // way 0
    apb(1'h1, CTRL_ADDR, 32'h0);
  endtask
  task automatic t_writeback();
    apb(1'h1, TA, 32'hE000_0000 | tw(T, 1'h0, 1'h1));
    rd(TA + 32'h8, tw(T, 1'h0, 1'h1));
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, 32'hF500_0040 + 32'(4 * i), 32'hA000_0000 + 32'(i));
    end
    n0 = tm.wb_n;
    apb(1'h1, TA, tw(T, 1'h1, 1'h1));
    chk({28'h0, tm.wb_n - n0}, 32'h0); // clean target, no write-back
    n0 = tm.wb_n;
    apb(1'h1, TA, tw(T2, 1'h0, 1'h1));
    wbchk(LA); // line out first
    rd(TA, tw(T2, 1'h0, 1'h1)); // direct store
  endtask
  task automatic t_assoc();
    apb(1'h1, TA, tw(T, 1'h1, 1'h1));
    apb(1'h1, AS, tw(T2, 1'h0, 1'h0));
    rd(TA, tw(T, 1'h1, 1'h1)); // mismatch dropped
    n0 = tm.wb_n;
    apb(1'h1, AS, tw(T, 1'h0, 1'h0));
    wbchk(LA); // dirty hit
    rd(TA, tw(T, 1'h0, 1'h0)); // flags cleared
    apb(1'h1, CTRL_ADDR, 32'h1);
    tlb_mode <= 2'h1;
    apb(1'h1, TA, tw(T + 19'h1, 1'h0, 1'h1));
    apb(1'h1, TA + 32'h8, 32'h8000_0000 | tw(T, 1'h0, 1'h0));
    rd(TA, tw(T + 19'h1, 1'h0, 1'h0)); // translated
    apb(1'h1, TA, tw(T + 19'h1, 1'h0, 1'h1));
    tlb_mode <= 2'h2;
    apb(1'h1, TA + 32'h8, 32'h8000_0000 | tw(T, 1'h0, 1'h0));
    chk({31'h0, e}, 32'h1); // multi hit
    tlb_mode <= 2'h0;
    apb(1'h1, TA + 32'h8, 32'h8000_0000 | tw(T, 1'h0, 1'h0));
    chk({31'h0, e}, 32'h0); // miss silent
    rd(TA, tw(T + 19'h1, 1'h0, 1'h1)); // untouched
    apb(1'h1, CTRL_ADDR, 32'h0);
  endtask
  // clock at 4 ns
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    results();
  end
  // longword accesses only
  // reset then scenarios; address low bits always zero
  initial begin
    arst_n_i = 1'h0;
    {psel_i, penable_i, pwrite_i} = 3'h0;
    {paddr_i, pwdata_i} = 64'h0;
    pstrb_i = 4'hF;
    pprot_i = 3'h1;
    tlb_mode = 2'h0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'h1;
    t_icache();
    t_ocache();
    t_writeback();
    t_assoc();
    results();
  end
endmodule
